// *** ssw_core.sv ***
// supply supervisor: power-on reset, second supply flag, bus watchdog
// ------------------------------------------------
// Contract
// - reset held after main supply good for 0.05, 0.2, 0.4 or 0.8 s
// - watchdog period 25 ms, 200 ms, 1.4 s, or off
// - chosen watchdog period survives a power cycle
// - start then stop on the two-wire bus restarts the watchdog
// - no restart within the period asserts the watchdog output
// - watchdog output is active low open drain, driven on expiry
// - low variant reset is open drain, held until supply good plus delay
// - high variant reset is push-pull with the same timing, inverted
// - second supply fail follows its comparator with no delay
// - power-up asserts reset until supply good for the delay
// - control writes blocked while power-on reset is active; mem_block resets to 0, so a write in the first cycle after resetn is taken
// - data line watched for restarts at all times
// - watchdog period comes from two retained control bits
// - control write then stop stores period and delay bits
// ------------------------------------------------
`timescale 1ns/1ps
`include "ssw_params.svh"
module ssw_core #(
    parameter bit          RESET_ACTIVE_HIGH = 1'b0,
    parameter logic [31:0] WD_CYC0           = `SSW_WD_C0,
    parameter logic [31:0] WD_CYC1           = `SSW_WD_C1,
    parameter logic [31:0] WD_CYC2           = `SSW_WD_C2,
    parameter logic [31:0] POR_CYC0          = `SSW_POR_C0,
    parameter logic [31:0] POR_CYC1          = `SSW_POR_C1,
    parameter logic [31:0] POR_CYC2          = `SSW_POR_C2,
    parameter logic [31:0] POR_CYC3          = `SSW_POR_C3
) (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic       nv_clear_n,
    input  wire logic       main_supply_above,
    input  wire logic       second_supply_sense,
    input  wire logic       scl_pin,
    input  wire logic       sda_pin,
    output logic            sda_val,
    output logic            sda_oe,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            reset_val,
    output logic            reset_oe,
    output logic            watchdog_timeout_n_val,
    output logic            watchdog_timeout_n_oe,
    output logic            second_supply_fail_n_val,
    output logic            second_supply_fail_n_oe,
    output logic            mem_block,
    output logic            irq
);

    ssw_pkg::ssw_core_type st;
    ssw_pkg::ssw_core_type next_st;
    ssw_nv_if              nv ();

    logic        start_evt;
    logic        stop_evt;
    logic        restart;
    logic        main_ok;
    logic [31:0] wd_lim;
    logic [31:0] por_lim;
    logic [2:0]  ev;
    logic        rst_act;

    // bus lines and second supply start at their idle level, so no false
    // edge and no second-supply event follow the release of reset
    localparam ssw_pkg::ssw_core_type RST_ST = '{
        sync1:   4'hE,
        sync2:   4'hE,
        scl_q:   1'b1,
        sda_q:   1'b1,
        por:     ssw_pkg::SSW_HOLD,
        rst_pin: RESET_ACTIVE_HIGH,
        rst_oe:  1'b1,
        mask:    `SSW_MASK_RST,
        default: '0
    };

    // ------------------------------------------------
    // selection decode
    // ------------------------------------------------
    // off gives zero; callers gate on the off code first
    function automatic logic [31:0] wd_limit(input logic [1:0] sel);
        unique case (sel)
            2'h0:    wd_limit = WD_CYC0;
            2'h1:    wd_limit = WD_CYC1;
            2'h2:    wd_limit = WD_CYC2;
            2'h3:    wd_limit = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] por_limit(input logic [1:0] sel);
        unique case (sel)
            2'h0:    por_limit = POR_CYC0;
            2'h1:    por_limit = POR_CYC1;
            2'h2:    por_limit = POR_CYC2;
            2'h3:    por_limit = POR_CYC3;
        endcase
    endfunction

    // ------------------------------------------------
    // retained settings
    // ------------------------------------------------
    ssw_nv_store u_nv (
        .sys_clk    (sys_clk),
        .clk_en     (clk_en),
        .nv_clear_n (nv_clear_n),
        .nv         (nv.store)
    );

    // pending byte is split into the layout of the control byte
    assign nv.commit  = st.commit;
    assign nv.wr_wdog = {st.pend_data[`SSW_B_WD_HI], st.pend_data[`SSW_B_WD_LO]};
    assign nv.wr_por  = {st.pend_data[`SSW_B_POR_HI], st.pend_data[`SSW_B_POR_LO]};

    // ------------------------------------------------
    // bus condition detection
    // ------------------------------------------------
    // edges use stage two and three only; stage one feeds stage two alone
    assign start_evt = st.sync2[`SSW_S_SCL] && st.scl_q
                       && st.sda_q && !st.sync2[`SSW_S_SDA];
    assign stop_evt  = st.sync2[`SSW_S_SCL] && st.scl_q
                       && !st.sda_q && st.sync2[`SSW_S_SDA];
    assign restart   = stop_evt && st.start_seen;
    assign main_ok   = st.sync2[`SSW_S_MAIN];
    assign wd_lim    = wd_limit(nv.wdog_sel);
    assign por_lim   = por_limit(nv.por_sel);

    // ------------------------------------------------
    // next state
    // ------------------------------------------------
    always_comb begin
        next_st = st;
        ev      = 3'h0;
        rst_act = 1'b1;

        // sda is sampled every cycle, never gated by reset or mode
        next_st.sync1   = {sda_pin, scl_pin, second_supply_sense, main_supply_above};
        next_st.sync2   = st.sync1;
        next_st.scl_q   = st.sync2[`SSW_S_SCL];
        next_st.sda_q   = st.sync2[`SSW_S_SDA];
        next_st.commit  = 1'b0;
        next_st.rd_data = 8'h00;
        next_st.od_zero = 1'b0;

        // power-on sequence: any dip restarts the whole delay
        unique case (st.por)
            ssw_pkg::SSW_HOLD: begin
                next_st.por_cnt = 32'h0000_0000;
                if (main_ok) begin
                    next_st.por = ssw_pkg::SSW_DELAY;
                end
            end
            ssw_pkg::SSW_DELAY: begin
                if (!main_ok) begin
                    next_st.por = ssw_pkg::SSW_HOLD;
                end else if (st.por_cnt == por_lim - 32'h0000_0001) begin
                    next_st.por = ssw_pkg::SSW_RUN;
                end else begin
                    next_st.por_cnt = st.por_cnt + 32'h0000_0001;
                end
            end
            ssw_pkg::SSW_RUN: begin
                if (!main_ok) begin
                    next_st.por     = ssw_pkg::SSW_HOLD;
                    next_st.por_cnt = 32'h0000_0000;
                    ev[`SSW_E_MAIN] = 1'b1;
                end
            end
            // the unused code falls back to holding the system in reset
            default: begin
                next_st.por = ssw_pkg::SSW_HOLD;
            end
        endcase

        // reset pin: same timing, polarity and drive set by the variant
        rst_act           = next_st.por != ssw_pkg::SSW_RUN;
        next_st.mem_block = rst_act;
        if (RESET_ACTIVE_HIGH) begin
            next_st.rst_pin = rst_act;
            next_st.rst_oe  = 1'b1;
        end else begin
            next_st.rst_pin = 1'b0;
            next_st.rst_oe  = rst_act;
        end

        // a stop clears the start memory whether or not it restarted
        if (start_evt) begin
            next_st.start_seen = 1'b1;
        end else if (stop_evt) begin
            next_st.start_seen = 1'b0;
        end

        // watchdog idles while off or while the system is held in reset
        if (nv.wdog_sel == `SSW_WD_OFF || st.por != ssw_pkg::SSW_RUN) begin
            next_st.wd_cnt     = 32'h0000_0000;
            next_st.wd_expired = 1'b0;
        end else if (restart) begin
            next_st.wd_cnt     = 32'h0000_0000;
            next_st.wd_expired = 1'b0;
        end else if (!st.wd_expired) begin
            if (st.wd_cnt == wd_lim - 32'h0000_0001) begin
                next_st.wd_expired = 1'b1;
            end else begin
                next_st.wd_cnt = st.wd_cnt + 32'h0000_0001;
            end
        end
        ev[`SSW_E_WDOG] = next_st.wd_expired && !st.wd_expired;

        // second supply flag has no delay beyond the synchroniser
        next_st.fail2_oe = !st.sync2[`SSW_S_SEC];
        ev[`SSW_E_SEC]   = next_st.fail2_oe && !st.fail2_oe;

        // a stop commits a pending control byte a cycle later from pend_data, so a write in
        // the same cycle replaces it, is stored by that stop and stays pending for the next
        if (stop_evt && st.pend_valid) begin
            next_st.commit     = 1'b1;
            next_st.pend_valid = 1'b0;
        end

        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                `SSW_A_CTRL: begin
                    if (!st.mem_block) begin
                        next_st.pend_valid = 1'b1;
                        next_st.pend_data  = reg_wdata;
                    end
                end
                `SSW_A_MASK: next_st.mask = reg_wdata[2:0];
                default:     next_st.mask = st.mask;
            endcase
        end

        // register reads; reading status clears it
        if (reg_rd) begin
            unique case (reg_addr)
                `SSW_A_CTRL: begin
                    next_st.rd_data[`SSW_B_POR_HI] = nv.por_sel[1];
                    next_st.rd_data[`SSW_B_WD_HI]  = nv.wdog_sel[1];
                    next_st.rd_data[`SSW_B_WD_LO]  = nv.wdog_sel[0];
                    next_st.rd_data[`SSW_B_POR_LO] = nv.por_sel[0];
                end
                `SSW_A_STAT: begin
                    next_st.rd_data = {5'h00, st.status};
                    next_st.status  = 3'h0;
                end
                `SSW_A_MASK: next_st.rd_data = {5'h00, st.mask};
                default:     next_st.rd_data = 8'h00;
            endcase
        end

        // new events win over a clearing read in the same cycle
        next_st.status = next_st.status | ev;
        next_st.irq    = |(next_st.status & next_st.mask);
    end

    // ------------------------------------------------
    // state register
    // ------------------------------------------------
    // clk_en low freezes everything, synchronisers included
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st <= RST_ST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------
    // outputs
    // ------------------------------------------------
    // open-drain pins only ever pull low, so the value is a held zero
    assign sda_val                  = st.od_zero;
    assign sda_oe                   = st.od_zero;
    assign reg_rdata                = st.rd_data;
    assign reset_val                = st.rst_pin;
    assign reset_oe                 = st.rst_oe;
    assign watchdog_timeout_n_val   = st.od_zero;
    assign watchdog_timeout_n_oe    = st.wd_expired;
    assign second_supply_fail_n_val = st.od_zero;
    assign second_supply_fail_n_oe  = st.fail2_oe;
    assign mem_block                = st.mem_block;
    assign irq                      = st.irq;

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_start;
        clk_en && start_evt;
    endsequence

    sequence s_stop;
        clk_en && stop_evt && st.start_seen;
    endsequence

    a_start_remembered: assert property (s_start |=> st.start_seen)
        else $error("start condition not remembered");

    a_wdog_restart_cnt: assert property (s_stop |=> st.wd_cnt == 32'h0000_0000 && !st.wd_expired)
        else $error("start then stop did not restart the watchdog");

    a_wdog_expires: assert property (clk_en && st.por == ssw_pkg::SSW_RUN && nv.wdog_sel != `SSW_WD_OFF
        && !st.wd_expired && !restart && st.wd_cnt == wd_limit(nv.wdog_sel) - 32'h0000_0001
        |=> watchdog_timeout_n_oe)
        else $error("watchdog did not expire at its period");

    a_wdog_no_early: assert property ($rose(watchdog_timeout_n_oe)
        |-> $past(st.wd_cnt) == wd_limit(nv.wdog_sel) - 32'h0000_0001)
        else $error("watchdog output asserted before the period ran out");

    a_wdog_off_quiet: assert property (nv.wdog_sel == `SSW_WD_OFF && $past(nv.wdog_sel) == `SSW_WD_OFF
        |-> !watchdog_timeout_n_oe)
        else $error("watchdog output active while off");

    a_por_release: assert property ($rose(st.por == ssw_pkg::SSW_RUN)
        |-> $past(st.por_cnt) == por_limit(nv.por_sel) - 32'h0000_0001)
        else $error("reset released before the power-on delay");

    a_por_hold_low: assert property (clk_en && !main_ok |=> st.por == ssw_pkg::SSW_HOLD)
        else $error("reset not asserted with the main supply low");

    a_rst_polarity: assert property (st.por != ssw_pkg::SSW_RUN
        |-> (RESET_ACTIVE_HIGH ? (reset_val && reset_oe) : (!reset_val && reset_oe)))
        else $error("reset pin not active while held");

    a_fail2_follow: assert property (clk_en |=> second_supply_fail_n_oe == !$past(st.sync2[`SSW_S_SEC]))
        else $error("second supply flag does not follow its input");

    a_ctrl_blocked: assert property (clk_en && reg_wr && reg_addr == `SSW_A_CTRL && st.mem_block
        |=> $stable(st.pend_data))
        else $error("control write taken during power-on reset");

    a_commit_on_stop: assert property (nv.commit |-> $past(stop_evt) && $past(st.pend_valid))
        else $error("settings stored without a stop");

    a_period_kept: assert property (!nv.commit && clk_en |=> $stable(nv.wdog_sel))
        else $error("watchdog period changed without a commit");

endmodule

// *** ssw_host_model.sv ***
// host processor model: drives the bus clock and pulls the data line low
`timescale 1ns/1ps
module ssw_host_model (
    output logic scl,
    output logic sda_low
);
    // ----------
    // idle bus
    // ----------
    // clock stands high and data is released between frames
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // ----------
    // frames
    // ----------
    // optional start, one clock pulse, then a stop; 24 ns steps hold the clock low for 48 ns
    // the clock only moves inside a frame, so the core never sees a free-running clock
    task automatic frame(input bit with_start);
        #7;
        if (with_start) begin
            sda_low = 1'b1;
            #24;
        end
        scl = 1'b0;
        #24;
        sda_low = 1'b1;
        #24;
        scl = 1'b1;
        #24;
        sda_low = 1'b0;
        #24;
    endtask
endmodule

// *** ssw_nv_if.sv ***
// link between the supervisor core and its retained setting store
`timescale 1ns/1ps
interface ssw_nv_if;
    logic       commit;
    logic [1:0] wr_wdog;
    logic [1:0] wr_por;
    logic [1:0] wdog_sel;
    logic [1:0] por_sel;
    modport core  (output commit, output wr_wdog, output wr_por, input wdog_sel, input por_sel);
    modport store (input commit, input wr_wdog, input wr_por, output wdog_sel, output por_sel);
endinterface

// *** ssw_nv_store.sv ***
// retained watchdog period and power-on delay selections
`timescale 1ns/1ps
`include "ssw_params.svh"
module ssw_nv_store (
    input wire logic sys_clk,
    input wire logic clk_en,
    input wire logic nv_clear_n,
    ssw_nv_if.store  nv
);

    ssw_pkg::ssw_nv_type st;
    ssw_pkg::ssw_nv_type next_st;

    // ------------------------------------------------
    // store
    // ------------------------------------------------
    // a commit overwrites both selections at once
    always_comb begin
        next_st = st;
        if (nv.commit) begin
            next_st.wdog = nv.wr_wdog;
            next_st.por  = nv.wr_por;
        end
    end

    // cleared only by nv_clear_n, never by the system reset,
    // so the selections ride through a power cycle
    always_ff @(posedge sys_clk or negedge nv_clear_n) begin
        if (!nv_clear_n) begin
            st <= '{wdog: `SSW_NV_WD_RST, por: `SSW_NV_POR_RST};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign nv.wdog_sel = st.wdog;
    assign nv.por_sel  = st.por;

endmodule

// *** ssw_params.svh ***
// constants of the supply supervisor and watchdog block
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH

// ------------------------------------------------
// clock and times
// ------------------------------------------------
`define SSW_CLK_MHZ     200
`define SSW_WD_T0_US    25000
`define SSW_WD_T1_US    200000
`define SSW_WD_T2_US    1400000
`define SSW_POR_T0_MS   50
`define SSW_POR_T1_MS   200
`define SSW_POR_T2_MS   400
`define SSW_POR_T3_MS   800
`define SSW_WD_C0       (`SSW_WD_T0_US * `SSW_CLK_MHZ)
`define SSW_WD_C1       (`SSW_WD_T1_US * `SSW_CLK_MHZ)
`define SSW_WD_C2       (`SSW_WD_T2_US * `SSW_CLK_MHZ)
`define SSW_POR_C0      (`SSW_POR_T0_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_POR_C1      (`SSW_POR_T1_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_POR_C2      (`SSW_POR_T2_MS * 1000 * `SSW_CLK_MHZ)
`define SSW_POR_C3      (`SSW_POR_T3_MS * 1000 * `SSW_CLK_MHZ)

// ------------------------------------------------
// registers and fields
// ------------------------------------------------
`define SSW_A_CTRL      2'h0
`define SSW_A_STAT      2'h1
`define SSW_A_MASK      2'h2
`define SSW_B_POR_HI    7
`define SSW_B_WD_HI     6
`define SSW_B_WD_LO     5
`define SSW_B_POR_LO    0
`define SSW_E_WDOG      0
`define SSW_E_MAIN      1
`define SSW_E_SEC       2
`define SSW_WD_OFF      2'h3
`define SSW_NV_WD_RST   2'h0
`define SSW_NV_POR_RST  2'h0
`define SSW_MASK_RST    3'h0

// ------------------------------------------------
// synchroniser lanes
// ------------------------------------------------
`define SSW_S_MAIN      0
`define SSW_S_SEC       1
`define SSW_S_SCL       2
`define SSW_S_SDA       3

`endif

// *** ssw_pkg.sv ***
// types of the supply supervisor and watchdog block
package ssw_pkg;

    typedef enum logic [1:0] {
        SSW_HOLD,
        SSW_DELAY,
        SSW_RUN
    } ssw_por_type;

    typedef struct packed {
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic        scl_q;
        logic        sda_q;
        ssw_por_type por;
        logic [31:0] por_cnt;
        logic [31:0] wd_cnt;
        logic        wd_expired;
        logic        start_seen;
        logic        pend_valid;
        logic [7:0]  pend_data;
        logic        commit;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic        irq;
        logic [7:0]  rd_data;
        logic        rst_pin;
        logic        rst_oe;
        logic        fail2_oe;
        logic        mem_block;
        logic        od_zero;
    } ssw_core_type;

    typedef struct packed {
        logic [1:0] wdog;
        logic [1:0] por;
    } ssw_nv_type;

endpackage

// *** tb_top.sv ***
// self-checking bench of the supervisor core against a host model
`timescale 1ns/1ps
module tb_top;
    logic       sys_clk;
    logic       resetn;
    logic       nv_clear_n;
    logic       en;
    logic       main_on;
    logic       sec_on;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] d;
    logic [7:0] b;
    logic [1:0] c;
    wire  [7:0] rdata;
    wire        rst_val, rst_oe, sda_val, sda_oe, wd_val, wd_oe;
    wire        f2_val, f2_oe, mem_block, irq, scl, sda_low;
    int         fails  = 0;
    int         checks = 0;
    int         cycles = 0;
    int         n;
    // expected timings in cycles, indexed by selection code
    int         wd_lim[4]  = '{40, 80, 120, 0};
    // codes 1 and 3 keep their full-length defaults; no power-up uses them
    int         por_lim[4] = '{20, 40000000, 40, 160000000};
    int         order[4]   = '{3, 0, 1, 2};

    // ----------
    // design, host and clock
    // ----------
    ssw_core #(
        .WD_CYC0           (32'h0000_0028),
        .WD_CYC1           (32'h0000_0050),
        .WD_CYC2           (32'h0000_0078),
        .POR_CYC0          (32'h0000_0014),
        .POR_CYC2          (32'h0000_0028)
    ) dut (
        .sys_clk                  (sys_clk),
        .resetn                   (resetn),
        .clk_en                   (en),
        .nv_clear_n               (nv_clear_n),
        .main_supply_above        (main_on),
        .second_supply_sense      (sec_on),
        .scl_pin                  (scl),
        .sda_pin                  (~(sda_low | sda_oe)),
        .sda_val                  (sda_val),
        .sda_oe                   (sda_oe),
        .reg_addr                 (addr),
        .reg_wdata                (wdata),
        .reg_wr                   (wr),
        .reg_rd                   (rd),
        .reg_rdata                (rdata),
        .reset_val                (rst_val),
        .reset_oe                 (rst_oe),
        .watchdog_timeout_n_val   (wd_val),
        .watchdog_timeout_n_oe    (wd_oe),
        .second_supply_fail_n_val (f2_val),
        .second_supply_fail_n_oe  (f2_oe),
        .mem_block                (mem_block),
        .irq                      (irq)
    );
    ssw_host_model host (
        .scl     (scl),
        .sda_low (sda_low)
    );
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----------
    // shared tasks
    // ----------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic in_range(input int v, input int lo, input int hi);
        check({31'h0, v >= lo && v <= hi}, 32'h0000_0001);
    endtask
    task automatic conclude;
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_read(input logic [1:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // cycles until reset releases (0) or the watchdog pulls low (1), bounded
    task automatic measure(input int which, output int cnt);
        cnt = 0;
        while (cnt < 400 && (which == 0 ? ~rst_oe : wd_oe) !== 1'b1) begin
            @(posedge sys_clk);
            cnt++;
        end
    endtask
    task automatic power_up(input int code);
        @(posedge sys_clk);
        main_on <= 1'b1;
        measure(0, n);
        in_range(n, por_lim[code], por_lim[code] + 5);
        check(mem_block, 1'b0);
    endtask
    // restart, then let the period run out with the mask fully open
    task automatic wd_run(input int code);
        host.frame(1'b1);
        repeat (2) @(posedge sys_clk);
        check(wd_oe, 1'b0);
        measure(1, n);
        in_range(n, wd_lim[code] - 6, wd_lim[code] + 2);
        check(wd_val, 1'b0);
        check(irq, 1'b1);
    endtask

    // ----------
    // hang guard
    // ----------
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    // ----------
    // main sequence
    // ----------
    initial begin
        resetn     = 1'b0;
        en         = 1'b1;
        nv_clear_n = 1'b0;
        main_on    = 1'b0;
        sec_on     = 1'b1;
        addr       = 2'h0;
        wdata      = 8'h00;
        wr         = 1'b0;
        rd         = 1'b0;
        void'($urandom(96));
        repeat (20) @(posedge sys_clk);
        resetn     <= 1'b1;
        nv_clear_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({rst_oe, rst_val, mem_block}, 3'h5);
        // a control write while held in power-on reset must be lost
        reg_write(2'h0, 8'h60);
        host.frame(1'b1);
        reg_read(2'h0, d);
        check(d, 8'h00);
        power_up(0);
        reg_write(2'h2, 8'h07);
        wd_run(0);
        reg_read(2'h1, d);
        check(d[0], 1'b1);
        check({irq, wd_oe}, 2'h1);
        // restarts at random spacing inside the period keep the output released
        repeat (6) begin
            host.frame(1'b1);
            repeat ($urandom_range(8, 0)) @(posedge sys_clk);
            check(wd_oe, 1'b0);
            // a frozen core must not count: the freeze outlasts the period
            @(posedge sys_clk);
            en <= 1'b0;
            repeat ($urandom_range(60, 45)) @(posedge sys_clk);
            check(wd_oe, 1'b0);
            en <= 1'b1;
        end
        // a stop with no start before it must not restart the count
        repeat (2) @(posedge sys_clk);
        host.frame(1'b0);
        measure(1, n);
        in_range(n, 0, 24);
        foreach (order[i]) begin
            c = order[i][1:0];
            b = {c[1], c[1], c[0], 4'h0, c[0]};
            reg_write(2'h0, b);
            if (c == 2'h3) begin
                host.frame(1'b1);
                repeat (200) @(posedge sys_clk);
                check(wd_oe, 1'b0);
            end else begin
                wd_run(order[i]);
            end
            reg_read(2'h0, d);
            check(d, b);
        end
        // brown-out, then a full power cycle: selections must survive
        @(posedge sys_clk);
        main_on <= 1'b0;
        repeat (5) @(posedge sys_clk);
        check({rst_oe, rst_val}, 2'h2);
        reg_read(2'h1, d);
        check(d[1], 1'b1);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        power_up(2);
        reg_read(2'h0, d);
        check(d, b);
        reg_write(2'h2, 8'h07);
        wd_run(2);
        // second supply flag follows its comparator with no delay
        @(posedge sys_clk);
        sec_on <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check({f2_oe, f2_val, irq, sda_oe, sda_val}, 5'h14);
        reg_read(2'h1, d);
        check(d[2], 1'b1);
        @(posedge sys_clk);
        sec_on <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check(f2_oe, 1'b0);
        conclude();
    end
endmodule
